// ===== core/apdu_pkg.sv
/*
 * Shared constants for the automatic power-down unit: register bit positions,
 * reset values, counter sizes and port-mode codes.
 * Assumes a single 100 MHz REF_CLK domain.
 */
package apdu_pkg;
    // Width of the idle counter.
    localparam int APDU_CNT_W = 4;
    // Idle periods of the external clock before power-down.
    localparam logic [3:0] APDU_IDLE_LIMIT = 4'h000F;
    // Bit positions in the first power-management register.
    localparam int APDU_A_APD_EN = 1;
    localparam int APDU_A_TURBO_OFF = 3;
    localparam int APDU_A_ARR_CLK_OFF = 4;
    localparam int APDU_A_MC_CLK_OFF = 5;
    // Writable bit masks; unused bits stay zero.
    localparam logic [7:0] APDU_A_MASK = 8'h003A;
    localparam logic [7:0] APDU_B_MASK = 8'h007C;
    // Power-up value of both registers.
    localparam logic [7:0] APDU_REG_RST = 8'h0000;
    // Port function codes, two bits per pin.
    localparam logic [1:0] APDU_FN_MCU_IO = 2'h0;
    localparam logic [1:0] APDU_FN_LOGIC_OUT = 2'h1;
    localparam logic [1:0] APDU_FN_ADDR_OUT = 2'h2;
    localparam logic [1:0] APDU_FN_DATA_IO = 2'h3;
    // Number of port pins handled.
    localparam int APDU_NPINS = 8;
endpackage : apdu_pkg

// ===== core/apdu_sync.sv
/*
 * Two-stage synchroniser for one level signal.
 * Assumes the destination clock and an active-low asynchronous reset.
 */
module apdu_sync
    import apdu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1; // First stage, read only by the second.
        logic s2; // Second stage, safe to use.
    } apdu_sync_s;

    apdu_sync_s r;
    apdu_sync_s next_r;

    // Shift the input through both stages.
    always_comb begin
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    // Register the stages; reset takes constants only.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule : apdu_sync

// ===== core/apdu_pin.sv
/*
 * Power-down handling for one port pin: holds, floats or drives low the pin
 * according to its function code.
 * Assumes inputs on REF_CLK domain; output registered.
 */
module apdu_pin
    import apdu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] fn,
    input wire logic pd,
    input wire logic dout,
    input wire logic doe,
    output logic pin_o,
    output logic pin_oe
);
    typedef struct packed {
        logic o;
        logic oe;
    } apdu_pin_s;

    apdu_pin_s r;
    apdu_pin_s next_r;

    // In power-down, I/O and logic outputs keep level; data pins float.
    always_comb begin
        next_r.o = dout;
        next_r.oe = doe;
        if (pd) begin
            unique case (fn)
                APDU_FN_MCU_IO, APDU_FN_LOGIC_OUT: begin
                    next_r = r;
                end
                APDU_FN_ADDR_OUT: begin
                    // Level is undefined; driving zero is a legal choice.
                    next_r.o = 1'b0;
                    next_r.oe = 1'b1;
                end
                APDU_FN_DATA_IO: begin
                    next_r.oe = 1'b0;
                end
            endcase
        end
    end

    // Register the pin outputs.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign pin_o = r.o;
    assign pin_oe = r.oe;
endmodule : apdu_pin

// ===== core/apdu_top.sv
/*
 * Automatic power-down unit: watches the MCU address strobe, counts idle
 * periods of the external clock input and enters power-down, gating the
 * MCU address and data from memories and logic, deselecting memories, and setting pins.
 * Assumes REF_CLK at 100 MHz, much faster than the external clock input.
 */
module apdu_top
    import apdu_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic POR_N,
    input wire logic ADDR_STROBE,
    input wire logic EXT_CLOCK_IN,
    input wire logic STROBE_POL,
    input wire logic CHIP_SEL_N,
    input wire logic [15:0] MCU_ADDR,
    input wire logic [7:0] MCU_DATA,
    input wire logic [4:0] MCU_CTRL,
    input wire logic REG_WR_A,
    input wire logic REG_WR_B,
    input wire logic [7:0] REG_WDATA,
    input wire logic [15:0] PORT_FN,
    input wire logic [7:0] PORT_DOUT,
    input wire logic [7:0] PORT_DOE,
    output logic POWER_DOWN_SIG,
    output logic [7:0] PWR_MGMT_REG_A,
    output logic [7:0] PWR_MGMT_REG_B,
    output logic [3:0] IDLE_COUNT,
    output logic [15:0] MEM_ADDR,
    output logic [7:0] MEM_DATA,
    output logic MEM_SELECT,
    output logic MEM_STANDBY,
    output logic [15:0] LOGIC_ADDR,
    output logic [7:0] LOGIC_DATA,
    output logic [4:0] LOGIC_CTRL,
    output logic LOGIC_CLK,
    output logic LOGIC_MC_CLK,
    output logic LOGIC_FULL_SPEED,
    output logic [7:0] PORT_O,
    output logic [7:0] PORT_OE
);
    // Reset release chain and synchronised pin levels.
    logic rst_q1;
    logic rst_n;
    logic strobe_s;
    logic clk_s;
    logic csn_s;

    // Release the reset through two flip-flops.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // Pins cross into REF_CLK through two stages each.
    apdu_sync u_sync_strobe (.clk(REF_CLK), .rst_n(NRST), .d(ADDR_STROBE), .q(strobe_s));
    apdu_sync u_sync_clk (.clk(REF_CLK), .rst_n(NRST), .d(EXT_CLOCK_IN), .q(clk_s));
    apdu_sync u_sync_csn (.clk(REF_CLK), .rst_n(NRST), .d(CHIP_SEL_N), .q(csn_s));

    typedef enum logic [1:0] {
        APDU_RUN = 2'b01, // Normal operation.
        APDU_PDN = 2'b10 // Power-down mode.
    } apdu_state_e;

    typedef struct packed {
        apdu_state_e st; // Mode state.
        logic [3:0] cnt; // Idle counter.
        logic strobe_d; // Delayed strobe for edge detection.
        logic clk_d; // Delayed clock for edge detection.
        logic csn_d; // Delayed chip select.
        logic [7:0] reg_a; // First power-management register.
        logic [7:0] reg_b; // Second power-management register.
        logic [15:0] mem_addr;
        logic [7:0] mem_data;
        logic mem_sel;
        logic mem_stby;
        logic [15:0] lg_addr;
        logic [7:0] lg_data;
        logic [4:0] lg_ctrl;
        logic lg_clk;
        logic lg_mc_clk;
        logic lg_fast;
    } apdu_s;

    apdu_s r;
    apdu_s next_r;

    // Register bank lives apart: it clears at power-up only.
    logic [7:0] reg_a;
    logic [7:0] reg_b;
    logic [7:0] next_reg_a;
    logic [7:0] next_reg_b;

    // Software writes; unused bits forced to zero.
    always_comb begin
        next_reg_a = reg_a;
        next_reg_b = reg_b;
        if (REG_WR_A) begin
            next_reg_a = REG_WDATA & APDU_A_MASK;
        end
        if (REG_WR_B) begin
            next_reg_b = REG_WDATA & APDU_B_MASK;
        end
    end

    // Only the power-up reset touches this bank, never NRST.
    always_ff @(posedge REF_CLK or negedge POR_N) begin
        if (!POR_N) begin
            reg_a <= APDU_REG_RST;
            reg_b <= APDU_REG_RST;
        end else begin
            reg_a <= next_reg_a;
            reg_b <= next_reg_b;
        end
    end

    logic apd_en;
    logic strobe_edge;
    logic clk_rise;
    logic idle_level;
    logic pd_now;

    // Derived events for the mode logic.
    always_comb begin
        apd_en = reg_a[APDU_A_APD_EN];
        strobe_edge = strobe_s ^ r.strobe_d;
        // Counter uses the raw clock, unaffected by blocking bits.
        clk_rise = clk_s & ~r.clk_d;
        idle_level = (strobe_s == STROBE_POL);
        pd_now = (r.st == APDU_PDN);
    end

    // Mode machine, counter and gated outputs.
    always_comb begin
        next_r = r;
        next_r.strobe_d = strobe_s;
        next_r.clk_d = clk_s;
        next_r.csn_d = csn_s;
        next_r.reg_a = reg_a;
        next_r.reg_b = reg_b;
        unique case (r.st)
            APDU_RUN: begin
                if (!apd_en || strobe_edge || !idle_level) begin
                    next_r.cnt = '0;
                end else if (clk_rise) begin
                    if (r.cnt == APDU_IDLE_LIMIT - 4'h0001) begin
                        next_r.cnt = APDU_IDLE_LIMIT;
                        next_r.st = APDU_PDN;
                    end else begin
                        next_r.cnt = r.cnt + 4'h0001;
                    end
                end
            end
            APDU_PDN: begin
                // Strobe activity, chip select falling or disable wakes us.
                if (strobe_edge || (r.csn_d && !csn_s) || !apd_en) begin
                    next_r.st = APDU_RUN;
                    next_r.cnt = '0;
                end
            end
            default: begin
                next_r.st = APDU_RUN;
                next_r.cnt = '0;
            end
        endcase
        // Bus to memories: frozen in power-down so memories stay quiet.
        if (!pd_now) begin
            next_r.mem_addr = MCU_ADDR;
            next_r.mem_data = MCU_DATA;
            next_r.lg_addr = MCU_ADDR;
            next_r.lg_data = MCU_DATA;
        end
        next_r.mem_sel = !pd_now && !csn_s;
        next_r.mem_stby = pd_now || csn_s;
        // Chip select leaves logic untouched; only blocking bits gate it.
        next_r.lg_ctrl = MCU_CTRL & ~reg_b[6:2];
        // Blocking the logic's clock copy leaves the counter's clock alone.
        next_r.lg_clk = clk_s & ~reg_a[APDU_A_ARR_CLK_OFF];
        next_r.lg_mc_clk = clk_s & ~reg_a[APDU_A_MC_CLK_OFF];
        // Full speed defaults on; power-down has no say here.
        next_r.lg_fast = ~reg_a[APDU_A_TURBO_OFF];
    end

    // Synchronous reset clears mode; releasing it leaves in normal mode.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            r <= '{st: APDU_RUN, lg_fast: 1'b1, default: '0};
        end else if (!rst_n) begin
            r <= '{st: APDU_RUN, lg_fast: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // Port pins; in power-down each pin is held, floated or driven low by its function code.
    for (genvar i = 0; i < APDU_NPINS; i++) begin : g_pin
        apdu_pin u_pin (
            .clk(REF_CLK),
            .rst_n(rst_n),
            .fn(PORT_FN[2*i +: 2]),
            .pd(pd_now),
            .dout(PORT_DOUT[i]),
            .doe(PORT_DOE[i]),
            .pin_o(PORT_O[i]),
            .pin_oe(PORT_OE[i])
        );
    end

    assign POWER_DOWN_SIG = pd_now;
    assign PWR_MGMT_REG_A = r.reg_a;
    assign PWR_MGMT_REG_B = r.reg_b;
    assign IDLE_COUNT = r.cnt;
    assign MEM_ADDR = r.mem_addr;
    assign MEM_DATA = r.mem_data;
    assign MEM_SELECT = r.mem_sel;
    assign MEM_STANDBY = r.mem_stby;
    assign LOGIC_ADDR = r.lg_addr;
    assign LOGIC_DATA = r.lg_data;
    assign LOGIC_CTRL = r.lg_ctrl;
    assign LOGIC_CLK = r.lg_clk;
    assign LOGIC_MC_CLK = r.lg_mc_clk;
    assign LOGIC_FULL_SPEED = r.lg_fast;

    // Entry happens only after the count reaches fifteen.
    property p_entry;
        @(posedge REF_CLK) disable iff (!rst_n)
        $rose(pd_now) |-> (r.cnt == APDU_IDLE_LIMIT) && apd_en;
    endproperty
    a_entry: assert property (p_entry) else $error("power-down without full count");

    // A strobe edge in power-down exits next cycle.
    property p_wake;
        @(posedge REF_CLK) disable iff (!rst_n)
        pd_now && strobe_edge |=> !pd_now;
    endproperty
    a_wake: assert property (p_wake) else $error("strobe did not wake");

    // Any strobe transition zeroes the counter.
    property p_clear;
        @(posedge REF_CLK) disable iff (!rst_n)
        strobe_edge |=> (r.cnt == 4'h0000);
    endproperty
    a_clear: assert property (p_clear) else $error("counter not cleared");

    // Memories never selected while in power-down.
    property p_desel;
        @(posedge REF_CLK) disable iff (!rst_n)
        pd_now |=> !MEM_SELECT && MEM_STANDBY;
    endproperty
    a_desel: assert property (p_desel) else $error("memory selected in power-down");

    // Address to memories frozen during power-down.
    property p_block;
        @(posedge REF_CLK) disable iff (!rst_n)
        pd_now && $past(pd_now) |-> $stable(MEM_ADDR);
    endproperty
    a_block: assert property (p_block) else $error("bus leaked in power-down");

    // Counter is held at zero while disabled.
    property p_disabled;
        @(posedge REF_CLK) disable iff (!rst_n)
        !apd_en |=> (r.cnt == 4'h0000) && !pd_now;
    endproperty
    a_disabled: assert property (p_disabled) else $error("counted while disabled");

    // Counter never runs off the polarity level.
    property p_level;
        @(posedge REF_CLK) disable iff (!rst_n)
        !pd_now && !idle_level |=> (r.cnt == 4'h0000);
    endproperty
    a_level: assert property (p_level) else $error("counted at wrong level");

    // Full speed follows bit 3 only.
    property p_fast;
        @(posedge REF_CLK) disable iff (!rst_n)
        ##1 (LOGIC_FULL_SPEED == ~$past(reg_a[APDU_A_TURBO_OFF]));
    endproperty
    a_fast: assert property (p_fast) else $error("full-speed mismatch");

    // Chip select high forces standby.
    property p_cs;
        @(posedge REF_CLK) disable iff (!rst_n)
        csn_s |=> MEM_STANDBY && !MEM_SELECT;
    endproperty
    a_cs: assert property (p_cs) else $error("memory active with select high");
endmodule : apdu_top

// ===== sim/apdu_mcu.sv
/*
 * Behavioural model of the host microcontroller: pulses the address strobe
 * and walks the bus while running, and rests the strobe while asleep.
 * Assumes the bench clock and that run, rest and gap are driven by the bench.
 */
module apdu_mcu
    import apdu_pkg::*;
(
    input wire logic clk,
    input wire logic run,
    input wire logic rest,
    input wire logic [3:0] gap,
    output logic strobe,
    output logic [15:0] addr,
    output logic [7:0] data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Cycles since the last strobe edge; gap sets prompt or slow pulsing.
    logic [3:0] cnt;
    // Bench inputs as they stood at the edge, so the bench's own update cannot race us.
    logic run_q;
    logic rest_q;
    logic [3:0] gap_q;

    // Start from a defined bus so nothing unknown reaches the unit.
    initial begin
        strobe = 1'b0;
        addr = 16'h1234;
        data = 8'h5A;
        cnt = 4'h0;
    end

    // Change only just after the edge, like the real bus driver.
    always @(posedge clk) begin
        run_q = run;
        rest_q = rest;
        gap_q = gap;
        #1;
        if (run_q) begin
            // Awake: toggle the strobe every gap+1 cycles with a new address.
            if (cnt >= gap_q) begin
                cnt = 4'h0;
                strobe = ~strobe;
                addr = addr + 16'h1357;
                data = data + 8'h3B;
            end else begin
                cnt = cnt + 4'h1;
            end
        end else begin
            // Asleep: strobe rests, and the floating bus keeps changing.
            strobe = rest_q;
            addr = ~addr;
            data = ~data;
            cnt = 4'h0;
        end
    end
endmodule : apdu_mcu

// ===== sim/apdu_top_tb.sv
/*
 * Self-checking bench for the automatic power-down unit.
 * Assumes the unit's top module and the host model; seed is fixed.
 */
module apdu_top_tb;
    import apdu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk, nrst, por_n, ext_clk, pol, cs_n, wr_a, wr_b, run, rest;
    logic strobe, pd, full_speed, mem_sel, mem_stby, lg_clk, lg_mc_clk;
    logic [3:0] gap, idle_count;
    logic [4:0] ctrl, logic_ctrl;
    logic [7:0] wdata, dout, doe, mdata, reg_a, reg_b, port_o, port_oe, d;
    logic [7:0] mem_data, lg_data, md, ld;
    logic [15:0] maddr, pfn, mem_addr, a, lg_addr, la;
    int n_fail = 0;
    int num_checks = 0;

    apdu_mcu apdu_mcu_inst (.clk(ref_clk), .run(run), .rest(rest), .gap(gap),
        .strobe(strobe), .addr(maddr), .data(mdata));

    apdu_top apdu_top_inst (.REF_CLK(ref_clk), .NRST(nrst), .POR_N(por_n),
        .ADDR_STROBE(strobe), .EXT_CLOCK_IN(ext_clk), .STROBE_POL(pol),
        .CHIP_SEL_N(cs_n), .MCU_ADDR(maddr), .MCU_DATA(mdata), .MCU_CTRL(ctrl),
        .REG_WR_A(wr_a), .REG_WR_B(wr_b), .REG_WDATA(wdata), .PORT_FN(pfn),
        .PORT_DOUT(dout), .PORT_DOE(doe), .POWER_DOWN_SIG(pd),
        .PWR_MGMT_REG_A(reg_a), .PWR_MGMT_REG_B(reg_b), .IDLE_COUNT(idle_count),
        .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .MEM_SELECT(mem_sel),
        .MEM_STANDBY(mem_stby), .LOGIC_ADDR(lg_addr), .LOGIC_DATA(lg_data),
        .LOGIC_CTRL(logic_ctrl), .LOGIC_CLK(lg_clk), .LOGIC_MC_CLK(lg_mc_clk),
        .LOGIC_FULL_SPEED(full_speed), .PORT_O(port_o), .PORT_OE(port_oe));

    // Fast system clock and a slow external clock of eight system cycles.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        ext_clk = 1'b0;
        forever #40 ext_clk = ~ext_clk;
    end

    // Advance n edges and land just after the last one.
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    // Compare one value, counting checks and mismatches.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Expected register contents: unused bits always read back as zero.
    function automatic logic [7:0] exp_reg(input logic sel, input logic [7:0] v);
        return sel ? (v & APDU_B_MASK) : (v & APDU_A_MASK);
    endfunction : exp_reg

    // One-cycle register write; contents show one cycle after the write edge.
    task automatic wr(input logic sel, input logic [7:0] v);
        wdata = v;
        wr_a = ~sel;
        wr_b = sel;
        step(1);
        wr_a = 1'b0;
        wr_b = 1'b0;
        step(2);
    endtask : wr

    // Stop the strobe; power-down must not come early, and must come in time.
    task automatic enter;
        int i;
        run = 1'b0;
        rest = pol;
        step(104);
        chk(16'(pd), 16'h0000);
        i = 0;
        while (pd !== 1'b1 && i < 40) begin
            step(1);
            i++;
        end
        chk(16'(pd), 16'h0001);
    endtask : enter

    // Exit must show within a few cycles with the counter cleared.
    task automatic left;
        step(6);
        chk(16'(pd), 16'h0000);
        chk(16'(idle_count), 16'h0000);
    endtask : left

    initial begin
        #200000;
        n_fail++;
        summarize();
    end

    // Ends the run with the verdict.
    task automatic summarize;
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    initial begin
        void'($urandom(78));
        {nrst, por_n, pol, cs_n, wr_a, wr_b, rest} = 7'h00;
        {run, gap, ctrl, wdata, dout, doe} = {1'b1, 4'h1, 5'h00, 8'h00, 8'hA5, 8'hFF};
        pfn = 16'h0000;
        step(6);
        nrst = 1'b1;
        por_n = 1'b1;
        step(3);
        chk(16'(reg_a), 16'h0000);
        chk(16'(reg_b), 16'h0000);
        chk(16'(full_speed), 16'h0001);
        // Random writes: unused bits read zero, blocking bits gate control.
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            wr(1'b0, d);
            chk(16'(reg_a), 16'(exp_reg(1'b0, d)));
            chk(16'(full_speed), 16'(!d[3]));
            d = 8'($urandom);
            ctrl = 5'($urandom);
            wr(1'b1, d);
            chk(16'(reg_b), 16'(exp_reg(1'b1, d)));
            chk(16'(logic_ctrl), 16'(ctrl & ~d[6:2]));
        end
        wr(1'b1, 8'h00);
        // Disabled unit never powers down, however long the strobe sleeps.
        wr(1'b0, 8'h00);
        run = 1'b0;
        step(200);
        chk(16'(pd), 16'h0000);
        // Enabled, but the strobe rests at the other level: no counting.
        rest = 1'b1;
        wr(1'b0, 8'h02);
        step(200);
        chk(16'(idle_count), 16'h0000);
        chk(16'(pd), 16'h0000);
        // Slow steady pulsing clears the counter long before it can reach the limit.
        run = 1'b1;
        gap = 4'h6;
        step(300);
        chk(16'(pd), 16'h0000);
        // From here the strobe toggles every cycle, so the counter stays cleared.
        gap = 4'h0;
        // Chip-select high alone parks the memories without power-down.
        cs_n = 1'b1;
        step(6);
        chk(16'(mem_sel), 16'h0000);
        chk(16'(mem_stby), 16'h0001);
        cs_n = 1'b0;
        step(6);
        chk(16'(mem_sel), 16'h0001);
        // Strobe, chip-select and reset exit paths, alternating strobe polarity.
        for (int k = 0; k < 4; k++) begin
            pol = k[0];
            pfn = 16'($urandom);
            dout = 8'($urandom);
            if (k == 3) begin
                wr(1'b0, 8'h3A);
            end
            step(10);
            enter();
            a = mem_addr;
            md = mem_data;
            la = lg_addr;
            ld = lg_data;
            step(5);
            chk(mem_addr, a);
            chk(16'(mem_data), 16'(md));
            chk(lg_addr, la);
            chk(16'(lg_data), 16'(ld));
            chk(16'(idle_count), 16'(APDU_IDLE_LIMIT));
            if (k == 3) begin
                chk(16'(lg_clk), 16'h0000);
                chk(16'(lg_mc_clk), 16'h0000);
            end
            chk(16'(mem_sel), 16'h0000);
            chk(16'(mem_stby), 16'h0001);
            chk(16'(full_speed), 16'(k != 3));
            for (int p = 0; p < 8; p++) begin
                if (pfn[2*p+:2] == APDU_FN_DATA_IO) begin
                    chk(16'(port_oe[p]), 16'h0000);
                end else if (pfn[2*p+1] == 1'b0) begin
                    chk(16'(port_o[p]), 16'(dout[p]));
                end
            end
            if (k == 1) begin
                cs_n = 1'b1;
                step(6);
                cs_n = 1'b0;
                // Strobe still rests, so only the select edge can wake the unit.
                step(4);
                chk(16'(pd), 16'h0000);
            end else if (k == 2) begin
                nrst = 1'b0;
                step(2);
                nrst = 1'b1;
                step(6);
                chk(16'(pd), 16'h0000);
                chk(16'(reg_a), 16'h0002);
            end
            run = 1'b1;
            left();
        end
        // Power-up reset alone clears the registers.
        por_n = 1'b0;
        step(2);
        por_n = 1'b1;
        step(3);
        chk(16'(reg_a), 16'h0000);
        summarize();
    end
endmodule : apdu_top_tb
